// ### dv/stack_limit_monitor.sv
// port-level assertions for the stack pointer limit checker
`timescale 1ns/1ps
`default_nettype none
`include "stack_consts.svh"
module stack_limit_monitor
    import stack_pkg::*;
(
    input wire logic  clk, srst, op_valid, op_ready, sp_wr, limit_wr,
    input wire logic  mem_we, mem_re, stack_error, err_overflow, err_underflow,
    input wire stack_op_e op,
    input wire pc_t   pc,
    input wire byte_t status_low_byte,
    input wire word_t push_data, ea_addr, limit_wr_data, stack_pointer_reg,
    input wire word_t stack_limit_reg, mem_waddr, mem_wdata, mem_raddr
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // short aliases; direct pointer or limit writes change the picture
    wire word_t      sp  = stack_pointer_reg;
    wire word_t      lim = stack_limit_reg;
    wire logic [6:0] pch = pc[22:16];
    wire logic       tk  = op_valid && op_ready && !sp_wr && !limit_wr;
    wire logic       ok  = sp >= `STK_FLOOR && sp <= lim;

    AST_PUSH: assert property (tk && op == OP_PUSH && ok |=> mem_we
        && mem_waddr == $past(sp) && sp == $past(sp) + 16'h2)
        else $error("push address or pointer step wrong");
    AST_POP: assert property (tk && op == OP_POP && sp >= 16'h0802
        |=> mem_re && mem_raddr == $past(sp) - 16'h2 && sp == mem_raddr)
        else $error("pop address or pointer step wrong");
    AST_CALL_HI: assert property (tk && op == OP_CALL && ok
        && sp + 16'h2 <= lim |=> ##1 mem_we
        && mem_wdata == {9'h000, $past(pch, 2)})
        else $error("call high word not zero extended");
    AST_EXC_HI: assert property (tk && op == OP_EXC && ok
        && sp + 16'h2 <= lim |=> ##1 mem_we
        && mem_wdata == {$past(status_low_byte, 2), 1'b0, $past(pch, 2)})
        else $error("exception high word wrong");
    AST_OVF: assert property (tk && op == OP_PUSH && sp > lim
        && sp >= `STK_FLOOR |=> stack_error && err_overflow && !mem_we
        && $stable(sp))
        else $error("push above limit not trapped");
    AST_EQ: assert property (tk && op == OP_PUSH && sp == lim
        |=> !stack_error && mem_we)
        else $error("push at limit trapped");
    AST_EA_LOW: assert property (tk && op == OP_EA
        && ea_addr < `STK_FLOOR |=> stack_error && err_underflow)
        else $error("low stack address not trapped");
    AST_POP_LOW: assert property (tk && op == OP_POP
        && sp < 16'h0802 |=> stack_error && err_underflow && !mem_re)
        else $error("pop under floor not trapped");
    AST_ABORT: assert property (tk && op == OP_CALL && sp > lim
        && sp >= `STK_FLOOR |=> stack_error && err_overflow && !mem_we
        && op_ready)
        else $error("trapped call did not drop its high word");
    AST_LIMIT: assert property (limit_wr
        |=> lim == ($past(limit_wr_data) & 16'hfffe))
        else $error("limit write or alignment wrong");

    cover property (stack_error && err_overflow);
    cover property (stack_error && err_underflow);
    cover property (tk && op == OP_EXC);
endmodule
bind stack_pointer_limit_checker stack_limit_monitor u_mon (.clk, .srst,
    .op_valid, .op_ready, .sp_wr, .limit_wr, .mem_we, .mem_re, .stack_error,
    .err_overflow, .err_underflow, .op, .pc, .status_low_byte, .push_data,
    .ea_addr, .limit_wr_data, .stack_pointer_reg, .stack_limit_reg,
    .mem_waddr, .mem_wdata, .mem_raddr);
`default_nettype wire

// ### dv/stack_mem_model.sv
// data memory behind the stack strobes, as the core would see it
`timescale 1ns/1ps
`default_nettype none
module stack_mem_model
    import stack_pkg::*;
(
    input wire logic  clk, mem_we, mem_re,
    input wire word_t mem_waddr, mem_wdata, mem_raddr,
    output word_t     rdata
);
    word_t mem [0:32767];
    // pop sees the word pushed there
    always_ff @(posedge clk) begin
        if (mem_we)
            mem[mem_waddr[15:1]] <= mem_wdata;
        // no read: show no stale word, the bench must not lean on it
        rdata <= mem_re ? mem[mem_raddr[15:1]] : ~rdata;
    end
endmodule
`default_nettype wire

// ### dv/stack_pointer_limit_checker_tb_top.sv
// self-checking bench for the stack pointer limit checker
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin err_count++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module stack_pointer_limit_checker_tb_top;
    import stack_pkg::*;
    logic      clk = 0, srst = 1, op_valid = 0, sp_wr = 0, limit_wr = 0;
    stack_op_e op = OP_PUSH;
    word_t     push_data = 16'h0, ea_addr = 16'h0;
    word_t     sp_wr_data = 16'h0, limit_wr_data = 16'h0;
    pc_t       pc = 23'h0;
    byte_t     status_low_byte = 8'h0;
    logic      op_ready, mem_we, mem_re, stack_error, err_overflow;
    logic      err_underflow;
    word_t     sp, lim, mem_waddr, mem_wdata, mem_raddr, rdata;
    int        err_count = 0, compares = 0;

    always #5 clk = ~clk;

    stack_pointer_limit_checker DUT (.clk, .srst, .op_valid, .op, .op_ready,
        .push_data, .pc, .status_low_byte, .ea_addr, .sp_wr, .sp_wr_data,
        .limit_wr, .limit_wr_data, .stack_pointer_reg(sp),
        .stack_limit_reg(lim), .mem_we, .mem_waddr, .mem_wdata, .mem_re,
        .mem_raddr, .stack_error, .err_overflow, .err_underflow);
    stack_mem_model u_mem (.clk, .mem_we, .mem_re, .mem_waddr, .mem_wdata,
        .mem_raddr, .rdata);

    // one request, held one cycle, results looked at after the edge
    task automatic go(stack_op_e o, word_t d);
        @(posedge clk);
        op_valid <= 1'b1;
        op <= o;
        push_data <= d;
        ea_addr <= d;
        @(posedge clk);
        op_valid <= 1'b0;
        #1;
    endtask
    // pointer or limit write; the idle edge after it keeps reads away
    task automatic wr(logic s, logic l, word_t d);
        @(posedge clk);
        sp_wr <= s;
        limit_wr <= l;
        sp_wr_data <= d;
        limit_wr_data <= d;
        @(posedge clk);
        sp_wr <= 1'b0;
        limit_wr <= 1'b0;
        #1;
    endtask
    task automatic trap(logic o, logic u);
        `CHK({stack_error, err_overflow, err_underflow}, {1'b1, o, u})
    endtask
    task automatic t_reset;
        `CHK(sp, 16'h0800)
        `CHK({op_ready, mem_we, mem_re, stack_error}, 4'h8)
    endtask
    task automatic t_push_pop;
        wr(1'b0, 1'b1, 16'h0805);
        `CHK(lim, 16'h0804)
        for (int i = 0; i < 3; i++) begin
            go(OP_PUSH, word_t'(16'hc0 + i));
            `CHK({mem_we, mem_waddr, mem_wdata}, {1'b1, word_t'(16'h0800 + 2 * i), word_t'(16'hc0 + i)})
        end
        go(OP_PUSH, 16'h00ff);
        trap(1'b1, 1'b0);
        `CHK({mem_we, sp}, {1'b0, 16'h0806})
        go(OP_POP, 16'h0);
        `CHK({mem_re, mem_raddr, sp}, {1'b1, 16'h0804, 16'h0804})
        @(posedge clk);
        #1 `CHK(rdata, 16'h00c2)
    endtask
    task automatic t_under;
        wr(1'b1, 1'b0, 16'h0800);
        go(OP_POP, 16'h0);
        trap(1'b0, 1'b1);
        `CHK({mem_re, sp}, {1'b0, 16'h0800})
        go(OP_EA, 16'h07fe);
        trap(1'b0, 1'b1);
        go(OP_EA, 16'h0900);
        `CHK({stack_error, mem_we, mem_re}, 3'h0)
    endtask
    task automatic t_pc;
        @(posedge clk);
        pc <= 23'h7f1234;
        status_low_byte <= 8'ha5;
        wr(1'b0, 1'b1, 16'h1000);
        wr(1'b1, 1'b0, 16'h0900);
        for (int k = 0; k < 2; k++) begin
            go(k ? OP_EXC : OP_CALL, 16'h0);
            `CHK({mem_we, mem_waddr, mem_wdata}, {1'b1, word_t'(16'h0900 + 4 * k), 16'h1234})
            `CHK(op_ready, 1'b0)
            @(posedge clk);
            #1 `CHK({mem_we, mem_waddr, mem_wdata}, {1'b1, word_t'(16'h0902 + 4 * k), k ? 16'ha57f : 16'h007f})
        end
        `CHK(sp, 16'h0908)
        // trapped low word drops the high word
        wr(1'b0, 1'b1, 16'h0904);
        go(OP_CALL, 16'h0);
        trap(1'b1, 1'b0);
        `CHK({mem_we, op_ready, sp}, {2'b01, 16'h0908})
        @(posedge clk);
        #1 `CHK({mem_we, op_ready}, 2'b01)
    endtask
    // reset in mid-run leaves the limit alone
    task automatic t_mid_reset;
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        #1 `CHK({sp, lim}, {16'h0800, 16'h0904})
        `CHK({op_ready, mem_we, stack_error, err_overflow}, 4'h8)
        go(OP_PUSH, 16'h0077);
        `CHK({mem_we, mem_waddr, sp}, {1'b1, 16'h0800, 16'h0802})
    endtask
    task automatic stop_test;
        $display("mismatches %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        #1 t_reset;
        t_push_pop;
        t_under;
        t_pc;
        t_mid_reset;
        stop_test;
    end
    // the run needs well under a thousand cycles
    initial begin
        #20us;
        err_count++;
        stop_test;
    end
endmodule
`default_nettype wire

// ### hdl/stack_check_if.sv
// carrier between the stack engine and its address comparator
`timescale 1ns/1ps
`default_nettype none
interface stack_check_if;
    logic [15:0] addr;        // stack-derived effective address
    logic [15:0] limit;       // current stack limit
    logic        check_push;  // address belongs to a push
    logic        overflow;    // push address above limit
    logic        underflow;   // address below floor

    modport engine (output addr, limit, check_push,
                    input  overflow, underflow);
    // comparator side; named cmp since the plain word is reserved
    modport cmp (input  addr, limit, check_push,
                 output overflow, underflow);
endinterface
`default_nettype wire

// ### hdl/stack_consts.svh
// constants for the stack pointer and stack limit checker
`ifndef STACK_CONSTS_SVH
`define STACK_CONSTS_SVH

// lowest legal stack address, below it lies the special register area
`define STK_FLOOR      16'h0800
// stack pointer value after reset
`define STK_SP_RESET   16'h0800
// one stack word in bytes
`define STK_WORD_STEP  16'h0002
// position of the forced-zero alignment bit
`define STK_ALIGN_BIT  0
// filler bit placed between status byte and upper pc bits on exception push
`define STK_EXC_FILL   1'b0
// upper nine bits of a call push word, zero-extended
`define STK_CALL_FILL  9'h000

`endif

// ### hdl/stack_limit_compare.sv
// combinational limit and floor comparator for stack addresses
`timescale 1ns/1ps
`default_nettype none
`include "stack_consts.svh"
module stack_limit_compare (
    stack_check_if.cmp chk       // address in, violation flags out
);
    // same-cycle unsigned compares, no pipeline stage
    always_comb begin
        // RULE11 strict greater test
        chk.overflow  = chk.check_push && (chk.addr > chk.limit);
        // RULE9 floor check
        chk.underflow = (chk.addr < `STK_FLOOR);
    end
endmodule
`default_nettype wire

// ### hdl/stack_pkg.sv
// types shared by the stack pointer limit checker
package stack_pkg;
    // one request from the core's address generation
    typedef enum logic [2:0] {
        OP_PUSH,
        OP_POP,
        OP_CALL,
        OP_EXC,
        OP_EA
    } stack_op_e;

    typedef logic [15:0] word_t;
    typedef logic [22:0] pc_t;
    typedef logic [7:0]  byte_t;
endpackage

// ### hdl/stack_pointer_limit_checker.sv
// stack pointer engine with limit and floor error detection
// Notes on behaviour
// RULE1 - The stack pointer always names the next free word and the stack grows upward.
// RULE2 - A push writes at the pointer then adds a word; a pop subtracts a word then reads there.
// RULE3 - A call pushes the program counter with its upper word zero-extended so its top bit is clear.
// RULE4 - An exception pushes the program counter with the low status byte beside its upper bits.
// RULE5 - The stack limit has no reset value and stays undefined until software writes it.
// RULE6 - Bit 0 of the stack limit is always held at zero for word alignment.
// RULE7 - Every effective address formed from the stack pointer is compared with the stack limit; the code limit-checks push addresses only.
// RULE8 - A push with the pointer equal to the limit is fine, and the push after it traps.
// RULE9 - A stack address below 0800h raises a stack error trap.
// RULE10 - Software should not read through the stack pointer in the instruction right after a limit write.
// RULE11 - A push address strictly above the limit is one stack error event to exception logic.
// RULE12 - Pointer and limit are 16-bit, compared unsigned in the same cycle as address generation.
`timescale 1ns/1ps
`default_nettype none
`include "stack_consts.svh"
module stack_pointer_limit_checker #(
    parameter int AW = 16                       // data address width
) (
    input  wire logic               clk,           // core clock
    input  wire logic               srst,          // sync reset, high
    input  wire logic               op_valid,      // request present
    input  wire stack_pkg::stack_op_e op,          // request kind
    output logic                    op_ready,      // request can be taken
    input  wire stack_pkg::word_t   push_data,     // data for plain push
    input  wire stack_pkg::pc_t     pc,            // program counter
    input  wire stack_pkg::byte_t   status_low_byte, // status low byte
    input  wire stack_pkg::word_t   ea_addr,       // other sp-based ea
    input  wire logic               sp_wr,         // direct pointer write
    input  wire stack_pkg::word_t   sp_wr_data,    // pointer write value
    input  wire logic               limit_wr,      // stack limit write
    input  wire stack_pkg::word_t   limit_wr_data, // limit write value
    output stack_pkg::word_t        stack_pointer_reg, // pointer value
    output stack_pkg::word_t        stack_limit_reg,   // limit value
    output logic                    mem_we,        // stack write strobe
    output stack_pkg::word_t        mem_waddr,     // stack write address
    output stack_pkg::word_t        mem_wdata,     // stack write data
    output logic                    mem_re,        // stack read strobe
    output stack_pkg::word_t        mem_raddr,     // stack read address
    output logic                    stack_error,   // trap event pulse
    output logic                    err_overflow,  // trap was overflow
    output logic                    err_underflow  // trap was underflow
);
    import stack_pkg::*;

    typedef enum logic {
        ST_IDLE,
        ST_PC_HI
    } push_state_e;

    push_state_e state;
    push_state_e next_state;
    word_t       pc_hi_word;     // second word of a pc push
    word_t       next_addr;      // address generated this cycle
    logic        next_is_push;   // this cycle writes the stack
    logic        next_is_pop;    // this cycle reads the stack
    logic        next_access;    // an address is generated at all
    word_t       next_wdata;     // word written this cycle
    logic        violation;      // either check fired
    logic        take;           // request accepted

    stack_check_if chk ();

    // new requests only while no pc push is half done
    assign op_ready = (state == ST_IDLE);
    assign take     = op_valid && op_ready;

    // address generation for the current cycle
    always_comb begin
        next_addr    = stack_pointer_reg;
        next_is_push = 1'b0;
        next_is_pop  = 1'b0;
        next_access  = 1'b0;
        next_wdata   = push_data;
        next_state   = state;
        case (state)
            ST_IDLE: begin
                if (take) begin
                    next_access = 1'b1;
                    case (op)
                        OP_PUSH: begin
                            // RULE2 write at pointer
                            next_is_push = 1'b1;
                        end
                        OP_POP: begin
                            // RULE2 decrement before read
                            next_addr   = stack_pointer_reg - `STK_WORD_STEP;
                            next_is_pop = 1'b1;
                        end
                        OP_CALL, OP_EXC: begin
                            // low pc word first, upper word next cycle
                            next_is_push = 1'b1;
                            next_wdata   = pc[15:0];
                            next_state   = ST_PC_HI;
                        end
                        OP_EA: begin
                            // RULE7 indexed sp access floor-checked only, no limit compare
                            next_addr = ea_addr;
                        end
                        default: begin
                            next_access = 1'b0;
                        end
                    endcase
                end
            end
            ST_PC_HI: begin
                next_access  = 1'b1;
                next_is_push = 1'b1;
                next_wdata   = pc_hi_word;
                next_state   = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // RULE7 every sp address goes to the comparator
    assign chk.addr       = next_addr;
    assign chk.limit      = stack_limit_reg;
    assign chk.check_push = next_is_push;

    // RULE12 same-cycle unsigned compare
    stack_limit_compare u_cmp (
        .chk (chk)
    );

    // RULE8 equal-to-limit push passes, next push exceeds
    assign violation = next_access && (chk.overflow || chk.underflow);

    // capture the upper pc word when a pc push is taken
    always_ff @(posedge clk) begin
        if (srst) begin
            pc_hi_word <= 16'h0000;
        end else if (take && op == OP_CALL) begin
            // RULE3 top bits zero-extended
            pc_hi_word <= {`STK_CALL_FILL, pc[22:16]};
        end else if (take && op == OP_EXC) begin
            // RULE4 status byte beside upper pc bits
            pc_hi_word <= {status_low_byte, `STK_EXC_FILL, pc[22:16]};
        end
    end

    // pc push sequencing; a trap on the low word abandons the high word
    always_ff @(posedge clk) begin
        if (srst) begin
            state <= ST_IDLE;
        end else if (violation) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // pointer update; a trapped access leaves the pointer untouched
    always_ff @(posedge clk) begin
        if (srst) begin
            stack_pointer_reg <= `STK_SP_RESET;
        end else if (sp_wr) begin
            stack_pointer_reg <= sp_wr_data;
            stack_pointer_reg[`STK_ALIGN_BIT] <= 1'b0;
        end else if (!violation && next_is_push) begin
            // RULE1 always the next free word
            stack_pointer_reg <= stack_pointer_reg + `STK_WORD_STEP;
        end else if (!violation && next_is_pop) begin
            stack_pointer_reg <= next_addr;
        end
    end

    // RULE5 deliberately outside the reset
    always_ff @(posedge clk) begin
        if (limit_wr) begin
            // RULE6 alignment bit forced low
            stack_limit_reg <= {limit_wr_data[15:1], 1'b0};
        end
    end

    // registered memory strobes; trapped accesses never reach memory
    always_ff @(posedge clk) begin
        if (srst) begin
            mem_we    <= 1'b0;
            mem_re    <= 1'b0;
            mem_waddr <= 16'h0000;
            mem_wdata <= 16'h0000;
            mem_raddr <= 16'h0000;
        end else begin
            mem_we <= next_is_push && !violation;
            mem_re <= next_is_pop && !violation;
            if (next_is_push) begin
                mem_waddr <= next_addr;
                mem_wdata <= next_wdata;
            end
            if (next_is_pop) begin
                mem_raddr <= next_addr;
            end
        end
    end

    // RULE11 one pulse per trapped access
    always_ff @(posedge clk) begin
        if (srst) begin
            stack_error   <= 1'b0;
            err_overflow  <= 1'b0;
            err_underflow <= 1'b0;
        end else begin
            stack_error <= violation;
            if (violation) begin
                // cause held until the next trap for exception logic
                err_overflow  <= chk.overflow;
                err_underflow <= chk.underflow;
            end
        end
    end

    // RULE10 limit is used as registered, so a read right after a write
    // sees the new value here; the core must still keep the spacing
endmodule
`default_nettype wire
